// file: pkg/atsc_cfg.svh
// constants of the time sync capture unit: offsets, fields, resets
// assumes inclusion by bare name from the package and the design files
`ifndef ATSC_CFG_SVH
`define ATSC_CFG_SVH

`define ATSC_ADDR_W 16
`define ATSC_OFS_HEADER 16'h0500
`define ATSC_OFS_DECL 16'h0504
`define ATSC_OFS_CTRL 16'h0520
`define ATSC_OFS_WALL 16'h0524
`define ATSC_OFS_STAMP_LO 16'h0528
`define ATSC_OFS_STAMP_HI 16'h052C
`define ATSC_OFS_FRAME_OFS 16'h0534

`define ATSC_HDR_REV_HI 31
`define ATSC_HDR_REV_LO 28
`define ATSC_HDR_ID_HI 27
`define ATSC_HDR_ID_LO 16
`define ATSC_HDR_PTR_HI 15
`define ATSC_HDR_PTR_LO 0
`define ATSC_HDR_RESET 32'h00011F00

`define ATSC_DECL_SYNC_ADJ_BIT 2
`define ATSC_DECL_SYNC_ADJ_VAL 1'h0

`define ATSC_CTRL_DONE_BIT 31
`define ATSC_CTRL_IE_BIT 30
`define ATSC_CTRL_INIT_BIT 5
`define ATSC_CTRL_SEL_HI 4
`define ATSC_CTRL_SEL_DIR_BIT 4
`define ATSC_CTRL_SEL_IDX_HI 3
`define ATSC_CTRL_SEL_W 5

`define ATSC_WALL_FN_LO 9
`define ATSC_FN_W 23
`define ATSC_CIF_W 9
`define ATSC_OFS_W 4
`define ATSC_POS_W 64
`define ATSC_MAX_ENGINES 16

`endif

// file: pkg/atsc_pkg.sv
// types of the time sync capture unit
// assumes atsc_cfg.svh is on the include path
`include "atsc_cfg.svh"

package atsc_pkg;
  typedef enum logic [0:0] {ATSC_IDLE, ATSC_ARMED} atsc_state_e;
  typedef logic [`ATSC_POS_W-1:0] atsc_pos_t;
  typedef logic [`ATSC_OFS_W-1:0] atsc_frame_ofs_t;
endpackage

// file: pkg/atsc_track_if.sv
// carrier between the capture core and the frame boundary tracker
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface atsc_track_if;
  import atsc_pkg::*;
  logic frame_tick;
  atsc_pos_t live_pos;
  atsc_pos_t held_pos;
  atsc_frame_ofs_t held_ofs;

  modport tracker (
    input frame_tick,
    input live_pos,
    output held_pos,
    output held_ofs
  );
  modport core (
    output frame_tick,
    output live_pos,
    input held_pos,
    input held_ofs
  );
endinterface

`default_nettype wire

// file: logic/atsc_track.sv
// frame boundary tracker: holds the selected link position as it stood
// at the last frame boundary and counts frames since it last changed
// assumes frame_tick is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none

module atsc_track
  import atsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // carrier
  atsc_track_if.tracker trk
);
  localparam atsc_frame_ofs_t OFS_MAX = 4'hF;

  // sampled only on the boundary, so mid-frame motion never leaks in
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trk.held_pos <= '0;
    end else if (trk.frame_tick) begin
      trk.held_pos <= trk.live_pos;
    end
  end

  // saturates: a longer stall reads as the largest count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trk.held_ofs <= '0;
    end else if (trk.frame_tick) begin
      if (trk.live_pos != trk.held_pos) begin
        trk.held_ofs <= '0;
      end else if (trk.held_ofs != OFS_MAX) begin
        trk.held_ofs <= trk.held_ofs + 4'h1;
      end
    end
  end

  property p_hold_on_tick;
    @(posedge clk) disable iff (!nrst)
    trk.frame_tick |=> trk.held_pos == $past(trk.live_pos);
  endproperty
  a_hold_on_tick: assert property (p_hold_on_tick)
    else $error("held position not taken at frame boundary");

  property p_ofs_reset;
    @(posedge clk) disable iff (!nrst)
    trk.frame_tick && (trk.live_pos != trk.held_pos) |=> trk.held_ofs == 4'h0;
  endproperty
  a_ofs_reset: assert property (p_ofs_reset)
    else $error("frame offset not cleared on position change");

  property p_ofs_steady;
    @(posedge clk) disable iff (!nrst)
    !trk.frame_tick |=> $stable(trk.held_ofs) && $stable(trk.held_pos);
  endproperty
  a_ofs_steady: assert property (p_ofs_steady)
    else $error("tracker moved between frame boundaries");
endmodule

`default_nettype wire

// file: logic/atsc_top.sv
// time sync capture unit: capability header and declaration, capture
// control, and the captured wall frame, stamp and frame offset values; link position is latched but never read out
// assumes the register port, timer, wall frame and link positions all
// come from logic on CORE_CLK; FRAME_TICK pulses once per audio frame
// Notes on behaviour
// - header holds revision and identifier, id one
// - header low half points to next capability
// - header writes ignored once config lock set
// - sync adjust supported bit reads zero
// - done flag set when capture completes
// - writing one clears done, zero ignored
// - enabled done feeds interrupt status and irq
// - writing one to initiate starts capture
// - initiate clears itself when capture completes
// - select picks outbound or inbound engine index
// - link position and stamp latched together
// - timer snapshot split into low and high
// - wall capture holds frame number and clock
// - captured values frozen while done set
// - offset counts frames since position changed
// - link position taken from last frame boundary
`timescale 1ns/100ps
`default_nettype none
`include "atsc_cfg.svh"

module atsc_top
  import atsc_pkg::*;
#(
  parameter int NUM_OUT = 16,
  parameter int NUM_IN = 16
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // register port
  input wire logic [`ATSC_ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // controller context
  input wire logic CONFIG_LOCK,
  input wire logic CTRL_INT_ENABLE,
  input wire logic GLOBAL_INT_ENABLE,
  // time sources
  input wire logic [63:0] RUN_TIMER,
  input wire logic [`ATSC_FN_W-1:0] FRAME_NUMBER,
  input wire logic [`ATSC_CIF_W-1:0] BIT_CLOCK_IN_FRAME,
  input wire logic FRAME_TICK,
  // link positions of every engine, engine n at bits n*64 upward
  input wire logic [NUM_OUT*64-1:0] OUT_LINK_POS,
  input wire logic [NUM_IN*64-1:0] IN_LINK_POS,
  // interrupt
  output logic CAPTURE_STATUS,
  output logic CAPTURE_IRQ
);
  localparam int POS_W = `ATSC_POS_W;
  localparam logic [31:0] HDR_RESET = `ATSC_HDR_RESET;

  generate
    if (NUM_OUT < 1 || NUM_OUT > `ATSC_MAX_ENGINES ||
        NUM_IN < 1 || NUM_IN > `ATSC_MAX_ENGINES) begin : g_bad_count
      $error("engine counts must lie between 1 and 16");
    end
  endgenerate

  // register state
  logic [3:0] rev_reg;
  logic [11:0] cap_id_reg;
  logic [15:0] next_ptr_reg;
  logic done_reg;
  logic done_ie_reg;
  logic initiate_reg;
  logic [`ATSC_CTRL_SEL_W-1:0] sel_reg;
  logic [`ATSC_FN_W-1:0] frame_num_cap_reg;
  logic [`ATSC_CIF_W-1:0] clk_in_frame_cap_reg;
  logic [31:0] stamp_lo_reg;
  logic [31:0] stamp_hi_reg;
  atsc_frame_ofs_t frame_ofs_reg;
  atsc_pos_t link_pos_reg;
  atsc_state_e state_reg;
  atsc_state_e state_next;
  logic irq_status_reg;
  logic irq_reg;
  logic [31:0] rdata_next;

  // decoded strobes
  logic wr_header;
  logic wr_ctrl;
  logic latch;
  atsc_pos_t sel_pos;

  assign wr_header = REG_WR && (REG_ADDR == `ATSC_OFS_HEADER);
  assign wr_ctrl = REG_WR && (REG_ADDR == `ATSC_OFS_CTRL);

  // frame boundary tracker
  atsc_track_if trk ();

  atsc_track u_track (
    .clk(CORE_CLK),
    .nrst(NRST),
    .trk(trk.tracker)
  );

  // out-of-range index yields zero rather than another engine
  always_comb begin
    logic [3:0] idx;
    idx = sel_reg[`ATSC_CTRL_SEL_IDX_HI:0];
    sel_pos = '0;
    if (sel_reg[`ATSC_CTRL_SEL_DIR_BIT]) begin
      if (32'(idx) < NUM_OUT) begin
        sel_pos = OUT_LINK_POS[idx*POS_W +: POS_W];
      end
    end else begin
      if (32'(idx) < NUM_IN) begin
        sel_pos = IN_LINK_POS[idx*POS_W +: POS_W];
      end
    end
  end

  assign trk.frame_tick = FRAME_TICK;
  assign trk.live_pos = sel_pos;

  // capability header, locked fields
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rev_reg <= HDR_RESET[`ATSC_HDR_REV_HI:`ATSC_HDR_REV_LO];
      cap_id_reg <= HDR_RESET[`ATSC_HDR_ID_HI:`ATSC_HDR_ID_LO];
      next_ptr_reg <= HDR_RESET[`ATSC_HDR_PTR_HI:`ATSC_HDR_PTR_LO];
    end else if (wr_header && !CONFIG_LOCK) begin
      rev_reg <= REG_WDATA[`ATSC_HDR_REV_HI:`ATSC_HDR_REV_LO];
      cap_id_reg <= REG_WDATA[`ATSC_HDR_ID_HI:`ATSC_HDR_ID_LO];
      next_ptr_reg <= REG_WDATA[`ATSC_HDR_PTR_HI:`ATSC_HDR_PTR_LO];
    end
  end

  // capture sequencer: a request made while an old result is still
  // unacknowledged waits, so that result is never overwritten
  always_comb begin
    state_next = state_reg;
    latch = 1'b0;
    case (state_reg)
      ATSC_IDLE: begin
        if (initiate_reg) begin
          state_next = ATSC_ARMED;
        end
      end
      ATSC_ARMED: begin
        if (!done_reg) begin
          latch = 1'b1;
          state_next = ATSC_IDLE;
        end
      end
      default: begin
        state_next = ATSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ATSC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // initiate: software sets, hardware clears on completion
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      initiate_reg <= 1'b0;
    end else if (latch) begin
      initiate_reg <= 1'b0;
    end else if (wr_ctrl && REG_WDATA[`ATSC_CTRL_INIT_BIT]) begin
      initiate_reg <= 1'b1;
    end
  end

  // done flag: set wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      done_reg <= 1'b0;
    end else if (latch) begin
      done_reg <= 1'b1;
    end else if (wr_ctrl && REG_WDATA[`ATSC_CTRL_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // plain control fields; select is taken as written, software is
  // expected to settle it before initiating
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      done_ie_reg <= 1'b0;
      sel_reg <= '0;
    end else if (wr_ctrl) begin
      done_ie_reg <= REG_WDATA[`ATSC_CTRL_IE_BIT];
      sel_reg <= REG_WDATA[`ATSC_CTRL_SEL_HI:0];
    end
  end

  // one coherent snapshot, taken only while done is clear
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      frame_num_cap_reg <= '0;
      clk_in_frame_cap_reg <= '0;
      stamp_lo_reg <= '0;
      stamp_hi_reg <= '0;
      link_pos_reg <= '0;
      frame_ofs_reg <= '0;
    end else if (latch) begin
      frame_num_cap_reg <= FRAME_NUMBER;
      clk_in_frame_cap_reg <= BIT_CLOCK_IN_FRAME;
      stamp_lo_reg <= RUN_TIMER[31:0];
      stamp_hi_reg <= RUN_TIMER[63:32];
      link_pos_reg <= trk.held_pos;
      frame_ofs_reg <= trk.held_ofs;
    end
  end

  // interrupt: registered so the outputs are glitch free
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_status_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= done_reg && done_ie_reg;
      irq_reg <= done_reg && done_ie_reg &&
                 CTRL_INT_ENABLE && GLOBAL_INT_ENABLE;
    end
  end

  assign CAPTURE_STATUS = irq_status_reg;
  assign CAPTURE_IRQ = irq_reg;

  // read mux; unmapped and reserved bits return zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (REG_ADDR)
      `ATSC_OFS_HEADER: begin
        rdata_next = {rev_reg, cap_id_reg, next_ptr_reg};
      end
      `ATSC_OFS_DECL: begin
        rdata_next[`ATSC_DECL_SYNC_ADJ_BIT] = `ATSC_DECL_SYNC_ADJ_VAL;
      end
      `ATSC_OFS_CTRL: begin
        rdata_next[`ATSC_CTRL_DONE_BIT] = done_reg;
        rdata_next[`ATSC_CTRL_IE_BIT] = done_ie_reg;
        rdata_next[`ATSC_CTRL_INIT_BIT] = initiate_reg;
        rdata_next[`ATSC_CTRL_SEL_HI:0] = sel_reg;
      end
      `ATSC_OFS_WALL: begin
        rdata_next = {frame_num_cap_reg, clk_in_frame_cap_reg};
      end
      `ATSC_OFS_STAMP_LO: begin
        rdata_next = stamp_lo_reg;
      end
      `ATSC_OFS_STAMP_HI: begin
        rdata_next = stamp_hi_reg;
      end
      `ATSC_OFS_FRAME_OFS: begin
        rdata_next[`ATSC_OFS_W-1:0] = frame_ofs_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end

  property p_done_on_capture;
    @(posedge CORE_CLK) disable iff (!NRST)
    state_reg == ATSC_ARMED && !done_reg |=> done_reg && !initiate_reg;
  endproperty
  a_done_on_capture: assert property (p_done_on_capture)
    else $error("capture did not complete in one cycle");

  property p_clear_on_one;
    @(posedge CORE_CLK) disable iff (!NRST)
    wr_ctrl && REG_WDATA[`ATSC_CTRL_DONE_BIT] && done_reg |=> !done_reg;
  endproperty
  a_clear_on_one: assert property (p_clear_on_one)
    else $error("done flag not cleared by write of one");

  property p_keep_on_zero;
    @(posedge CORE_CLK) disable iff (!NRST)
    wr_ctrl && !REG_WDATA[`ATSC_CTRL_DONE_BIT] && done_reg |=> done_reg;
  endproperty
  a_keep_on_zero: assert property (p_keep_on_zero)
    else $error("done flag lost on write of zero");

  property p_irq_gate;
    @(posedge CORE_CLK) disable iff (!NRST)
    ##1 CAPTURE_IRQ == ($past(done_reg) && $past(done_ie_reg) &&
      $past(CTRL_INT_ENABLE) && $past(GLOBAL_INT_ENABLE));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by the three enables");

  property p_start;
    @(posedge CORE_CLK) disable iff (!NRST)
    wr_ctrl && REG_WDATA[`ATSC_CTRL_INIT_BIT] && !done_reg &&
      state_reg == ATSC_IDLE |=> initiate_reg ##2 done_reg;
  endproperty
  a_start: assert property (p_start)
    else $error("write of one did not start a capture");

  property p_no_start;
    @(posedge CORE_CLK) disable iff (!NRST)
    !initiate_reg && !(wr_ctrl && REG_WDATA[`ATSC_CTRL_INIT_BIT])
      |=> !initiate_reg;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("initiate set without a write of one");

  property p_init_clears;
    @(posedge CORE_CLK) disable iff (!NRST)
    initiate_reg && !done_reg |-> ##[1:2] !initiate_reg;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("initiate not cleared after capture");

  property p_frozen;
    @(posedge CORE_CLK) disable iff (!NRST)
    done_reg ##1 done_reg |-> $stable(stamp_lo_reg) &&
      $stable(stamp_hi_reg) && $stable(link_pos_reg) &&
      $stable(frame_num_cap_reg) && $stable(clk_in_frame_cap_reg) &&
      $stable(frame_ofs_reg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("captured values moved while done set");

  property p_coherent;
    @(posedge CORE_CLK) disable iff (!NRST)
    latch |=> stamp_lo_reg == $past(RUN_TIMER[31:0]) &&
      stamp_hi_reg == $past(RUN_TIMER[63:32]) &&
      link_pos_reg == $past(trk.held_pos);
  endproperty
  a_coherent: assert property (p_coherent)
    else $error("snapshot not taken as one set");

  property p_locked;
    @(posedge CORE_CLK) disable iff (!NRST)
    wr_header && CONFIG_LOCK |=> $stable({rev_reg, cap_id_reg, next_ptr_reg});
  endproperty
  a_locked: assert property (p_locked)
    else $error("header changed while locked");

  property p_decl_zero;
    @(posedge CORE_CLK) disable iff (!NRST)
    REG_RD && REG_ADDR == `ATSC_OFS_DECL |=> REG_RDATA == 32'h00000000;
  endproperty
  a_decl_zero: assert property (p_decl_zero)
    else $error("declaration register not zero");
endmodule

`default_nettype wire

// file: dv/atsc_tb.sv
// bench for the time sync capture unit: register tasks and scenarios
// assumes atsc_pkg and atsc_top are compiled first, cfg header on path
`timescale 1ns/100ps
`default_nettype none
`include "atsc_cfg.svh"

module tb;
  import atsc_pkg::*;
  logic core_clk;
  logic nrst;
  logic [`ATSC_ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic lock;
  logic ctrl_ie;
  logic glob_ie;
  logic [63:0] run_timer;
  logic [`ATSC_FN_W-1:0] frame_num;
  logic [`ATSC_CIF_W-1:0] clk_in_frame;
  logic frame_tick;
  logic [127:0] out_pos;
  logic [127:0] in_pos;
  logic cap_status;
  logic cap_irq;
  logic [31:0] rv;
  int failures;
  int cmp_count;

  // two engines each way keeps the position buses short
  atsc_top #(.NUM_OUT(2), .NUM_IN(2)) u_dut (
    .CORE_CLK(core_clk), .NRST(nrst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .CONFIG_LOCK(lock),
    .CTRL_INT_ENABLE(ctrl_ie), .GLOBAL_INT_ENABLE(glob_ie),
    .RUN_TIMER(run_timer), .FRAME_NUMBER(frame_num),
    .BIT_CLOCK_IN_FRAME(clk_in_frame), .FRAME_TICK(frame_tick),
    .OUT_LINK_POS(out_pos), .IN_LINK_POS(in_pos),
    .CAPTURE_STATUS(cap_status), .CAPTURE_IRQ(cap_irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e,
                       input string what);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, e);
  endtask

  // inbound engine 1 moves before each tick when chg is set
  task automatic tick(input int n, input logic chg);
    repeat (n) begin
      @(negedge core_clk);
      if (chg) in_pos[127:64] = in_pos[127:64] + 64'h40;
      frame_tick = 1'b1;
      @(negedge core_clk);
      frame_tick = 1'b0;
      repeat (2) @(negedge core_clk);
    end
  endtask

  // bounded poll; a capture that never finishes ends the run
  task automatic wait_done();
    int i;
    for (i = 0; i < 20; i++) begin
      rd(`ATSC_OFS_CTRL, rv);
      if (rv[31] === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      $display("[FAIL] capture done expected 1 seen timeout");
      tally_and_finish();
    end
  endtask

  initial begin
    #200000;
    failures++;
    $display("[FAIL] run end expected before limit seen timeout");
    tally_and_finish();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    nrst = 1'b0;
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
    lock = 1'b0;
    ctrl_ie = 1'b1;
    glob_ie = 1'b0;
    run_timer = 64'h0123456789ABCDEF;
    frame_num = 23'h5A5A5;
    clk_in_frame = 9'h1C3;
    frame_tick = 1'b0;
    out_pos = {64'h0000000000001000, 64'h0};
    in_pos = {64'h0000000000002000, 64'h0};
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    rdchk(`ATSC_OFS_HEADER, 32'h00011F00, "header");
    rdchk(`ATSC_OFS_DECL, 32'h0, "declaration");
    rdchk(`ATSC_OFS_CTRL, 32'h0, "control");
    rdchk(`ATSC_OFS_STAMP_HI, 32'h0, "stamp high");
    rdchk(`ATSC_OFS_FRAME_OFS, 32'h0, "frame offset");
    wr(16'h0510, 32'hFFFFFFFF);
    rdchk(16'h0510, 32'h0, "unmapped");
    wr(`ATSC_OFS_DECL, 32'hFFFFFFFF);
    rdchk(`ATSC_OFS_DECL, 32'h0, "declaration write");
    wr(`ATSC_OFS_HEADER, 32'h21230000);
    rdchk(`ATSC_OFS_HEADER, 32'h21230000, "header write");
    lock = 1'b1;
    wr(`ATSC_OFS_HEADER, 32'h00011F00);
    rdchk(`ATSC_OFS_HEADER, 32'h21230000, "header locked");
    // initiate left at zero, done one on a clear flag
    wr(`ATSC_OFS_CTRL, 32'hFFFFFFDF);
    rdchk(`ATSC_OFS_CTRL, 32'h4000001F, "control rsvd");
    // outbound engine 1 still for many frames: offset saturates
    wr(`ATSC_OFS_CTRL, 32'h40000011);
    tick(20, 1'b1);
    wr(`ATSC_OFS_CTRL, 32'h40000031);
    wait_done();
    chk("control done", rv, 32'hC0000011);
    rdchk(`ATSC_OFS_WALL, {frame_num, clk_in_frame}, "wall frame");
    rdchk(`ATSC_OFS_STAMP_LO, 32'h89ABCDEF, "stamp low");
    rdchk(`ATSC_OFS_STAMP_HI, 32'h01234567, "stamp high");
    rdchk(`ATSC_OFS_FRAME_OFS, 32'hF, "offset out");
    chk("status", {31'h0, cap_status}, 32'h1);
    chk("irq gated", {31'h0, cap_irq}, 32'h0);
    glob_ie = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("irq", {31'h0, cap_irq}, 32'h1);
    // sources move and a second request waits while done stands
    run_timer = 64'hFEDCBA9876543210;
    frame_num = 23'h00011;
    tick(2, 1'b1);
    wr(`ATSC_OFS_CTRL, 32'h40000031);
    wr(`ATSC_OFS_CTRL, 32'h40000011);
    rdchk(`ATSC_OFS_CTRL, 32'hC0000031, "zero to done");
    rdchk(`ATSC_OFS_STAMP_LO, 32'h89ABCDEF, "frozen low");
    rdchk(`ATSC_OFS_WALL, {23'h5A5A5, 9'h1C3}, "frozen wall");
    rdchk(`ATSC_OFS_FRAME_OFS, 32'hF, "frozen offset");
    wr(`ATSC_OFS_CTRL, 32'hC0000011);
    wait_done();
    chk("pending done", rv, 32'hC0000011);
    rdchk(`ATSC_OFS_STAMP_HI, 32'hFEDCBA98, "new stamp high");
    rdchk(`ATSC_OFS_STAMP_LO, 32'h76543210, "new stamp low");
    rdchk(`ATSC_OFS_WALL, {23'h00011, 9'h1C3}, "new wall");
    // clear with the enable dropped
    wr(`ATSC_OFS_CTRL, 32'h80000011);
    rdchk(`ATSC_OFS_CTRL, 32'h00000011, "cleared");
    chk("status off", {31'h0, cap_status}, 32'h0);
    chk("irq off", {31'h0, cap_irq}, 32'h0);
    // inbound engine 1 moves every frame: offset stays zero
    wr(`ATSC_OFS_CTRL, 32'h00000001);
    tick(5, 1'b1);
    wr(`ATSC_OFS_CTRL, 32'h00000021);
    wait_done();
    chk("inbound done", rv, 32'h80000001);
    rdchk(`ATSC_OFS_FRAME_OFS, 32'h0, "offset in");
    chk("status masked", {31'h0, cap_status}, 32'h0);
    // second reset in mid-run
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    rdchk(`ATSC_OFS_HEADER, 32'h00011F00, "header again");
    rdchk(`ATSC_OFS_CTRL, 32'h0, "control again");
    rdchk(`ATSC_OFS_STAMP_LO, 32'h0, "stamp again");
    tally_and_finish();
  end
endmodule

`default_nettype wire
